// *** src/gcs_consts.svh ***
`ifndef GCS_CONSTS_SVH
`define GCS_CONSTS_SVH

`define GCS_GLOBAL_ADDR      7'h77
`define GCS_ADDR_BITS        7
`define GCS_CFG_RESET        16'h0000
`define GCS_CONV_TIME_NS     64'd133333333
`define GCS_CLK_PERIOD_NS    64'd40
`define GCS_CONV_CYCLES      ((`GCS_CONV_TIME_NS + `GCS_CLK_PERIOD_NS - 64'd1) / `GCS_CLK_PERIOD_NS)
`define GCS_CAL_PHASE_CYCLES 32'd16

`endif

// *** src/gcs_conv_seq.sv ***
`timescale 1ns/10ps
`include "gcs_consts.svh"

// conversion timer: offset-calibration phase then signal phase, then sleep
module gcs_conv_seq #(
    parameter logic [31:0] CONV_CYCLES = 32'(`GCS_CONV_CYCLES),
    parameter logic [31:0] CAL_CYCLES  = `GCS_CAL_PHASE_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        start_conv,
    output logic             busy,
    output logic             cal_phase,
    output logic             done_pulse
);
    logic [31:0] cnt_r;
    logic        busy_r;
    logic        done_r;

    wire last_cycle = busy_r && (cnt_r == CONV_CYCLES - 32'h1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_r  <= 32'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= last_cycle;
            if (start_conv) begin
                busy_r <= 1'b1;
                cnt_r  <= 32'h0;
            end else if (last_cycle) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    assign busy       = busy_r;
    assign cal_phase  = busy_r && (cnt_r < CAL_CYCLES);
    assign done_pulse = done_r;
endmodule

// *** src/gcs_i2c_sync.sv ***
`timescale 1ns/10ps
`include "gcs_consts.svh"

module gcs_i2c_sync #(
    parameter logic [31:0] CONV_CYCLES = 32'(`GCS_CONV_CYCLES),
    parameter logic [6:0]  OWN_ADDR    = 7'h14
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             conv_start,
    output logic             converting,
    output logic             calibrating,
    output logic             asleep,
    output logic [7:0]       chan_sel,
    output logic [7:0]       conf_sel,
    output logic             own_addr_hit
);
    logic [1:0] scl_s_r, sda_s_r;
    logic       scl_q_r, sda_q_r;
    gcs_pkg::gcs_line_ev_type ev;
    gcs_pkg::gcs_bus_state_type st_r, st_nxt;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic       global_w_r;
    logic       byte_ok_r;
    logic [7:0] byte_r;
    gcs_pkg::gcs_cfg_type cfg_r;
    logic       sda_oe_r, start_r, own_hit_r;
    logic       busy, cal, done;
    logic       sleep_r, cal_r;
    logic       conv_r;

    // two-flop synchronisers on both pins, one more stage for edge detect
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
            scl_q_r <= scl_s_r[1];
            sda_q_r <= sda_s_r[1];
        end
    end

    assign ev.sda   = sda_s_r[1];
    assign ev.rise  = scl_s_r[1] && !scl_q_r;
    assign ev.fall  = !scl_s_r[1] && scl_q_r;
    assign ev.start = scl_s_r[1] && scl_q_r && sda_q_r && !sda_s_r[1];
    assign ev.stop  = scl_s_r[1] && scl_q_r && !sda_q_r && sda_s_r[1];

    wire [6:0] rx_addr   = sh_r[7:1];
    wire       rx_rw     = sh_r[0];
    wire       is_global = (rx_addr == `GCS_GLOBAL_ADDR);
    wire       is_own    = (rx_addr == OWN_ADDR);
    // eight bits in; the ninth clock carries the acknowledge
    wire       byte_done = (bit_r == 4'h8);
    // global write selects regardless of strap address
    wire       ack_glob  = is_global && !rx_rw;
    // global read never acknowledged; own address never acknowledged, only flagged when not busy
    wire       ack_own   = is_own && !busy;
    wire       ack_addr  = ack_glob;

    // byte-level parser; start and stop override every state
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            gcs_pkg::GCS_IDLE:  st_nxt = st_r;
            gcs_pkg::GCS_ADDR:  if (ev.fall && byte_done) begin
                st_nxt = ack_addr ? gcs_pkg::GCS_AACK : gcs_pkg::GCS_SKIP;
            end
            gcs_pkg::GCS_AACK:  if (ev.fall) begin
                st_nxt = gcs_pkg::GCS_WDATA;
            end
            gcs_pkg::GCS_WDATA: if (ev.fall && byte_done) begin
                st_nxt = gcs_pkg::GCS_DACK;
            end
            gcs_pkg::GCS_DACK:  if (ev.fall) begin
                st_nxt = gcs_pkg::GCS_SKIP;
            end
            gcs_pkg::GCS_SKIP:  st_nxt = st_r;
            gcs_pkg::GCS_RDATA: st_nxt = gcs_pkg::GCS_SKIP;
            default:            st_nxt = gcs_pkg::GCS_IDLE;
        endcase
        if (ev.start) begin
            st_nxt = gcs_pkg::GCS_ADDR;
        end else if (ev.stop) begin
            st_nxt = gcs_pkg::GCS_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= gcs_pkg::GCS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // bit counter restarts on every start and every state change
    wire shifting = (st_r == gcs_pkg::GCS_ADDR) || (st_r == gcs_pkg::GCS_WDATA);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_r <= 4'h0;
            sh_r  <= 8'h00;
        end else if (ev.start || (st_nxt != st_r)) begin
            bit_r <= 4'h0;
        end else if (shifting && ev.rise && !byte_done) begin
            sh_r  <= {sh_r[6:0], ev.sda};
            bit_r <= bit_r + 4'h1;
        end
    end

    // acknowledge and byte capture
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            global_w_r <= 1'b0;
            byte_ok_r  <= 1'b0;
            byte_r     <= 8'h00;
            own_hit_r  <= 1'b0;
        end else begin
            if (ev.start) begin
                global_w_r <= 1'b0;
                byte_ok_r  <= 1'b0;
                own_hit_r  <= 1'b0;
            end else if (ev.stop) begin
                // a later stray stop must not restart conversion again
                global_w_r <= 1'b0;
                byte_ok_r  <= 1'b0;
            end else if (st_r == gcs_pkg::GCS_ADDR && ev.fall && byte_done) begin
                global_w_r <= ack_glob;
                own_hit_r  <= ack_own;
            end else if (st_r == gcs_pkg::GCS_WDATA && ev.fall && byte_done) begin
                byte_ok_r <= 1'b1;
                byte_r    <= sh_r;
            end
        end
    end

    // only the acknowledge bit drives the line; reads get no data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sda_oe_r <= 1'b0;
        end else if (ev.stop || ev.start) begin
            sda_oe_r <= 1'b0;
        end else if (ev.fall) begin
            sda_oe_r <= (st_nxt == gcs_pkg::GCS_AACK) || (st_nxt == gcs_pkg::GCS_DACK);
        end
    end

    // stop ends a global write: load byte if any, start conversion
    wire sync_stop = ev.stop && global_w_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_r   <= gcs_pkg::gcs_cfg_type'(`GCS_CFG_RESET);
            start_r <= 1'b0;
        end else begin
            start_r <= sync_stop;
            if (sync_stop && byte_ok_r) begin
                // same channel encoding as an addressed write
                cfg_r.chan <= byte_r;
            end
            // bare stop leaves cfg_r untouched
        end
    end

    // timer opens every conversion with the offset-calibration phase
    gcs_conv_seq #(
        .CONV_CYCLES (CONV_CYCLES)
    ) u_conv (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .start_conv  (start_r),
        .busy        (busy),
        .cal_phase   (cal),
        .done_pulse  (done)
    );

    // sleep once conversion ends until the next request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sleep_r <= 1'b1;
            conv_r  <= 1'b0;
            cal_r   <= 1'b0;
        end else begin
            cal_r <= cal;
            if (start_r) begin
                sleep_r <= 1'b0;
                conv_r  <= 1'b1;
            end else if (done) begin
                sleep_r <= 1'b1;
                conv_r  <= 1'b0;
            end
        end
    end

    // open drain: the line is only ever pulled low
    assign sda_out      = 1'b0;
    assign sda_oe       = sda_oe_r;
    assign conv_start   = start_r;
    assign converting   = conv_r;
    assign calibrating  = cal_r;
    assign asleep       = sleep_r;
    assign chan_sel     = cfg_r.chan;
    assign conf_sel     = cfg_r.conf;
    assign own_addr_hit = own_hit_r;
endmodule

// *** src/gcs_pkg.sv ***
package gcs_pkg;

    typedef enum logic [6:0] {
        GCS_IDLE  = 7'b0000001,
        GCS_ADDR  = 7'b0000010,
        GCS_AACK  = 7'b0000100,
        GCS_WDATA = 7'b0001000,
        GCS_DACK  = 7'b0010000,
        GCS_SKIP  = 7'b0100000,
        GCS_RDATA = 7'b1000000
    } gcs_bus_state_type;

    typedef struct packed {
        logic       start;
        logic       stop;
        logic       rise;
        logic       fall;
        logic       sda;
    } gcs_line_ev_type;

    typedef struct packed {
        logic [7:0] chan;
        logic [7:0] conf;
    } gcs_cfg_type;

endpackage

// *** test/gcs_asserts.sv ***
`timescale 1ns/10ps
module gcs_asserts (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       conv_start,
    input wire logic       converting,
    input wire logic       calibrating,
    input wire logic       asleep,
    input wire logic [7:0] chan_sel,
    input wire logic [7:0] conf_sel,
    input wire logic       own_addr_hit
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*5])
        else $error("ack released early");
    ack_end_a: assert property ($rose(sda_oe) |-> ##[5:14] !sda_oe)
        else $error("ack held too long");
    start_pulse_a: assert property (conv_start |=> !conv_start && converting)
        else $error("start pulse wrong");
    chan_load_a: assert property ($changed(chan_sel) |-> conv_start)
        else $error("channel changed without start");
    conf_keep_a: assert property (conf_sel == 8'h00)
        else $error("configuration changed");
    cal_len_a: assert property ($rose(calibrating) |-> ##15 calibrating ##1 !calibrating)
        else $error("calibration length wrong");
    cal_each_a: assert property (conv_start |-> ##[0:2] calibrating)
        else $error("no calibration in conversion");
    sleep_excl_a: assert property (asleep != converting)
        else $error("sleep and converting disagree");
    sleep_hold_a: assert property (asleep && !conv_start |=> asleep)
        else $error("woke without request");
    hit_idle_a: assert property ($rose(own_addr_hit) |-> asleep)
        else $error("own address taken while busy");
    cover property (conv_start);
    cover property ($rose(sda_oe));
    cover property ($fell(calibrating));
endmodule

// *** test/gcs_i2c_sync_bench.sv ***
`timescale 1ns/10ps
module gcs_i2c_sync_bench;
    logic       sys_clk, rst, scl_in, sda_in, sda_m, sda_out, sda_oe, a, ab, s;
    logic       conv_start, converting, calibrating, asleep, own_addr_hit;
    logic [7:0] chan_sel, conf_sel, exp_chan, d;
    int         n_errors, samples_checked, seed;
    assign sda_in = sda_m & (sda_oe ? sda_out : 1'b1);
    gcs_i2c_sync #(.CONV_CYCLES(32'd200)) gcs_i2c_sync_inst (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .sda_out      (sda_out),
        .sda_oe       (sda_oe),
        .conv_start   (conv_start),
        .converting   (converting),
        .calibrating  (calibrating),
        .asleep       (asleep),
        .chan_sel     (chan_sel),
        .conf_sel     (conf_sel),
        .own_addr_hit (own_addr_hit)
    );
    gcs_master gcs_master_inst (.sys_clk(sys_clk), .sda(sda_in), .scl_in(scl_in),
        .sda_m(sda_m));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("n_errors %0d samples_checked %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic frame(input logic [7:0] adr, input logic more, input logic [7:0] b);
        ab = 1'b0;
        s = 1'b0;
        gcs_master_inst.start();
        gcs_master_inst.xfer(adr, a);
        if (more) gcs_master_inst.xfer(b, ab);
        gcs_master_inst.stop();
        repeat (40) begin
            @(negedge sys_clk);
            if (conv_start === 1'b1) s = 1'b1;
        end
    endtask
    task automatic gsync(input logic more, input logic [7:0] b);
        int k;
        frame(8'hee, more, b);
        if (more) exp_chan = b;
        chk(8'(a), 8'h01);
        chk(8'(ab), 8'(more));
        chk(8'(s), 8'h01);
        chk(chan_sel, exp_chan);
        chk(8'(converting), 8'h01);
        frame(8'h28, 1'b0, 8'h00);
        chk(8'(a), 8'h00);
        chk(8'(own_addr_hit), 8'h00);
        k = 0;
        while (asleep !== 1'b1 && k < 400) begin
            @(negedge sys_clk);
            k++;
        end
        chk(8'(k < 400), 8'h01);
        if (k == 400) results();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        n_errors = 0;
        samples_checked = 0;
        seed = 32'haf62;
        exp_chan = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(8'({asleep, converting, calibrating, sda_oe, conv_start}), 8'h10);
        chk(chan_sel, 8'h00);
        frame(8'h28, 1'b0, 8'h00);
        chk(8'(s), 8'h00);
        chk(8'(own_addr_hit), 8'h01);
        frame(8'hef, 1'b0, 8'h00);
        chk(8'(a), 8'h00);
        chk(8'(s), 8'h00);
        for (int i = 0; i < 6; i++) begin
            d = (i == 1) ? 8'hff : (i == 3) ? 8'h00 : 8'($random(seed));
            gsync(i != 0 && i != 2, d);
        end
        results();
    end
endmodule
bind gcs_i2c_sync gcs_asserts gcs_asserts_inst (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .conv_start   (conv_start),
    .converting   (converting),
    .calibrating  (calibrating),
    .asleep       (asleep),
    .chan_sel     (chan_sel),
    .conf_sel     (conf_sel),
    .own_addr_hit (own_addr_hit)
);

// *** test/gcs_master.sv ***
`timescale 1ns/10ps
// bus master; scl idles high outside frames, sda released to pull-up
module gcs_master (
    input  wire logic sys_clk,
    input  wire logic sda,
    output logic      scl_in,
    output logic      sda_m
);
    initial begin
        scl_in = 1'b1;
        sda_m  = 1'b1;
    end
    task automatic ph(input logic c, input logic b);
        @(posedge sys_clk);
        scl_in <= c;
        sda_m  <= b;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic start();
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            ph(1'b0, b[i]);
            ph(1'b1, b[i]);
        end
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        @(negedge sys_clk);
        ack = ~sda;
    endtask
endmodule
